// >>> core/status_flags_defs.svh
// constants for the core flag and bank select register
// assumes 9-bit file addresses from the execution logic
`ifndef STATUS_FLAGS_DEFS_SVH
`define STATUS_FLAGS_DEFS_SVH
// mirrored file addresses, one per bank
`define ALIAS_BANK0 9'h003
`define ALIAS_BANK1 9'h083
`define ALIAS_BANK2 9'h103
`define ALIAS_BANK3 9'h183
// field positions
`define INDIRECT_PAGE_BIT 7
`define DIRECT_PAGE_HI 6
`define DIRECT_PAGE_LO 5
`define WDOG_EXPIRY_BIT 4
`define SLEEP_ENTERED_BIT 3
`define ZERO_BIT 2
`define NIBBLE_OVF_BIT 1
`define CARRY_BIT 0
// bit whose carry-out feeds the nibble flag, and the byte msb
`define NIBBLE_MSB 3
`define BYTE_MSB 7
// power-up value, alu flags taken as zero
`define FLAGS_POR_VALUE 8'h18
`endif

// >>> core/status_flags_pkg.sv
// types shared by the core flag register and its surroundings
// assumes nothing beyond the instruction clock domain
package status_flags_pkg;
  // how the current instruction affects the alu flags
  typedef enum logic [2:0] {
    FLAG_NONE,
    FLAG_LOGIC,
    FLAG_ADD,
    FLAG_SUB,
    FLAG_ROTL,
    FLAG_ROTR
  } flag_op_e;
  // file register access from the execution unit
  typedef struct packed {
    logic [8:0] addr;
    logic rdEn;
    logic wrEn;
    logic [7:0] wrData;
  } file_req_s;
  // alu operands and the result of a logic operation
  typedef struct packed {
    flag_op_e op;
    logic [7:0] opA;
    logic [7:0] opB;
    logic [7:0] result;
  } alu_req_s;
  // reset-cause events, one-cycle pulses
  typedef struct packed {
    logic wdtKick;
    logic sleepExec;
    logic wdtTimeout;
  } core_event_s;
endpackage

// >>> core/cpu_status_flag_register.sv
// core flag and bank select register of the 8-bit core
// assumes the execution unit drives all requests on sys_clk
`include "status_flags_defs.svh"
module cpu_status_flag_register (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic warmReset,
  input wire status_flags_pkg::file_req_s fileReq,
  input wire status_flags_pkg::alu_req_s aluReq,
  input wire status_flags_pkg::core_event_s coreEvent,
  input wire logic [6:0] directOffset,
  input wire logic [7:0] indirectPtr,
  output logic [7:0] statusValue,
  output logic [7:0] readData_r,
  output logic readHit_r,
  output logic indirect_page_select,
  output logic [1:0] direct_page_select,
  output logic [8:0] directAddr,
  output logic [8:0] indirectAddr
);
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic aliasHit;
  logic statusWrite;
  logic flagInstr;
  logic subMode;
  logic [7:0] addendB;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic zeroNxt;
  logic nibbleNxt;
  logic carryNxt;
  logic updZero;
  logic updNibble;
  logic updCarry;

  // any of the four bank mirrors selects the one register
  always_comb begin
    if (fileReq.addr == `ALIAS_BANK0) begin
      aliasHit = 1'b1;
    end else if (fileReq.addr == `ALIAS_BANK1) begin
      aliasHit = 1'b1;
    end else if (fileReq.addr == `ALIAS_BANK2) begin
      aliasHit = 1'b1;
    end else if (fileReq.addr == `ALIAS_BANK3) begin
      aliasHit = 1'b1;
    end else begin
      aliasHit = 1'b0;
    end
  end

  // an instruction may name this register as its destination
  assign statusWrite = fileReq.wrEn && aliasHit;
  assign flagInstr = aluReq.op != status_flags_pkg::FLAG_NONE;

  // subtract as add of two's complement of the second operand
  assign subMode = aluReq.op == status_flags_pkg::FLAG_SUB;
  assign addendB = subMode ? ~aluReq.opB : aluReq.opB;
  assign sum9 = {1'b0, aluReq.opA} + {1'b0, addendB}
    + {8'h00, subMode};
  assign nib5 = {1'b0, aluReq.opA[`NIBBLE_MSB:0]}
    + {1'b0, addendB[`NIBBLE_MSB:0]} + {4'h0, subMode};

  // flag values and which flags this instruction touches
  always_comb begin
    zeroNxt = 1'b0;
    nibbleNxt = 1'b0;
    carryNxt = 1'b0;
    updZero = 1'b0;
    updNibble = 1'b0;
    updCarry = 1'b0;
    case (aluReq.op)
      status_flags_pkg::FLAG_LOGIC: begin
        zeroNxt = aluReq.result == 8'h00;
        updZero = 1'b1;
      end
      status_flags_pkg::FLAG_ADD,
      status_flags_pkg::FLAG_SUB: begin
        zeroNxt = sum9[`BYTE_MSB:0] == 8'h00;
        nibbleNxt = nib5[4];
        carryNxt = sum9[8];
        updZero = 1'b1;
        updNibble = 1'b1;
        updCarry = 1'b1;
      end
      status_flags_pkg::FLAG_ROTL: begin
        carryNxt = aluReq.opA[`BYTE_MSB];
        updCarry = 1'b1;
      end
      status_flags_pkg::FLAG_ROTR: begin
        carryNxt = aluReq.opA[0];
        updCarry = 1'b1;
      end
      default: begin
        zeroNxt = 1'b0;
      end
    endcase
  end

  // next register value: writes, alu flags and reset-cause events
  always_comb begin
    status_nxt = status_r;
    if (statusWrite) begin
      status_nxt[`INDIRECT_PAGE_BIT] = fileReq.wrData[`INDIRECT_PAGE_BIT];
      status_nxt[`DIRECT_PAGE_HI] = fileReq.wrData[`DIRECT_PAGE_HI];
      status_nxt[`DIRECT_PAGE_LO] = fileReq.wrData[`DIRECT_PAGE_LO];
      // written alu flags are dropped when the instruction sets flags
      if (!flagInstr) begin
        status_nxt[`ZERO_BIT] = fileReq.wrData[`ZERO_BIT];
        status_nxt[`NIBBLE_OVF_BIT] = fileReq.wrData[`NIBBLE_OVF_BIT];
        status_nxt[`CARRY_BIT] = fileReq.wrData[`CARRY_BIT];
      end
    end
    if (updZero) begin
      status_nxt[`ZERO_BIT] = zeroNxt;
    end
    if (updNibble) begin
      status_nxt[`NIBBLE_OVF_BIT] = nibbleNxt;
    end
    if (updCarry) begin
      status_nxt[`CARRY_BIT] = carryNxt;
    end
    // reset-cause flags move only on events, never on writes
    if (coreEvent.wdtKick) begin
      status_nxt[`WDOG_EXPIRY_BIT] = 1'b1;
      status_nxt[`SLEEP_ENTERED_BIT] = 1'b1;
    end else if (coreEvent.sleepExec) begin
      status_nxt[`WDOG_EXPIRY_BIT] = 1'b1;
      status_nxt[`SLEEP_ENTERED_BIT] = 1'b0;
    end
    if (coreEvent.wdtTimeout) begin
      status_nxt[`WDOG_EXPIRY_BIT] = 1'b0;
    end
  end

  // register update; warm reset clears only the bank selects
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_r <= `FLAGS_POR_VALUE;
    end else if (warmReset) begin
      status_r <= status_nxt;
      status_r[`INDIRECT_PAGE_BIT] <= 1'b0;
      status_r[`DIRECT_PAGE_HI] <= 1'b0;
      status_r[`DIRECT_PAGE_LO] <= 1'b0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // read port, one cycle latency, zero when not addressed
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      readData_r <= 8'h00;
      readHit_r <= 1'b0;
    end else begin
      readHit_r <= fileReq.rdEn && aliasHit;
      readData_r <= (fileReq.rdEn && aliasHit) ? status_r : 8'h00;
    end
  end

  // bank selection for direct and indirect addressing
  assign statusValue = status_r;
  assign indirect_page_select = status_r[`INDIRECT_PAGE_BIT];
  assign direct_page_select =
    status_r[`DIRECT_PAGE_HI:`DIRECT_PAGE_LO];
  assign directAddr = {direct_page_select, directOffset};
  assign indirectAddr = {indirect_page_select, indirectPtr};

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // written alu flags yield to the instruction's own flags
  aluOverride_a: assert property (
    statusWrite && (aluReq.op == status_flags_pkg::FLAG_LOGIC)
    && !warmReset |=> status_r[`ZERO_BIT] == $past(zeroNxt)
    && $stable(status_r[`CARRY_BIT]))
    else $error("alu flag write not suppressed");

  // reset-cause flags move on events only
  resetFlagsRo_a: assert property (
    !coreEvent.wdtKick && !coreEvent.sleepExec
    && !coreEvent.wdtTimeout |=>
    $stable(status_r[`WDOG_EXPIRY_BIT:`SLEEP_ENTERED_BIT]))
    else $error("reset-cause flag changed without event");

  // every mirror writes and reads the same register
  aliasWrite_a: assert property (
    statusWrite && !warmReset |=> status_r[7:5] == $past(fileReq.wrData[7:5]))
    else $error("bank select write lost");
  aliasRead_a: assert property (
    fileReq.rdEn && aliasHit |=> readHit_r && readData_r == $past(status_r))
    else $error("alias read mismatch");

  // bank selects feed the direct and indirect addresses
  pageMap_a: assert property (
    directAddr[8:7] == status_r[6:5] && indirectAddr[8] == status_r[7])
    else $error("bank mapping wrong");

  // kick, sleep and timeout on the reset-cause flags
  kickSleep_a: assert property (
    coreEvent.sleepExec && !coreEvent.wdtKick && !coreEvent.wdtTimeout
    |=> status_r[`WDOG_EXPIRY_BIT] && !status_r[`SLEEP_ENTERED_BIT])
    else $error("sleep flags wrong");
  kickSets_a: assert property (
    coreEvent.wdtKick && !coreEvent.wdtTimeout
    |=> status_r[`WDOG_EXPIRY_BIT] && status_r[`SLEEP_ENTERED_BIT])
    else $error("kick did not set flags");
  timeoutClr_a: assert property (
    coreEvent.wdtTimeout |=> !status_r[`WDOG_EXPIRY_BIT])
    else $error("timeout did not clear flag");

  // add, subtract and rotate carry behaviour
  addFlags_a: assert property (
    aluReq.op == status_flags_pkg::FLAG_ADD |=>
    status_r[`CARRY_BIT] == $past(({1'b0, aluReq.opA}
    + {1'b0, aluReq.opB}) > 9'h0FF) && status_r[`NIBBLE_OVF_BIT] ==
    $past(({1'b0, aluReq.opA[3:0]} + {1'b0, aluReq.opB[3:0]}) > 5'h0F))
    else $error("add flags wrong");
  subBorrow_a: assert property (
    aluReq.op == status_flags_pkg::FLAG_SUB |=>
    status_r[`CARRY_BIT] == $past(aluReq.opA >= aluReq.opB)
    && status_r[`ZERO_BIT] == $past(aluReq.opA == aluReq.opB))
    else $error("subtract borrow wrong");
  rotCarry_a: assert property (
    aluReq.op == status_flags_pkg::FLAG_ROTR
    |=> status_r[`CARRY_BIT] == $past(aluReq.opA[0]))
    else $error("rotate carry wrong");
  rotLeft_a: assert property (
    aluReq.op == status_flags_pkg::FLAG_ROTL
    |=> status_r[`CARRY_BIT] == $past(aluReq.opA[`BYTE_MSB]))
    else $error("rotate left carry wrong");

  // subtraction: digit flag is the inverted nibble borrow
  subNibble_a: assert property (
    aluReq.op == status_flags_pkg::FLAG_SUB |=>
    status_r[`NIBBLE_OVF_BIT] == $past(aluReq.opA[`NIBBLE_MSB:0]
    >= aluReq.opB[`NIBBLE_MSB:0]))
    else $error("subtract digit borrow wrong");

  // addition: zero flag follows the truncated sum
  addZero_a: assert property (
    aluReq.op == status_flags_pkg::FLAG_ADD |=>
    status_r[`ZERO_BIT] == $past(8'(aluReq.opA + aluReq.opB) == 8'h00))
    else $error("add zero flag wrong");

  // flags that an op does not own keep their value
  logicKeeps_a: assert property (
    aluReq.op == status_flags_pkg::FLAG_LOGIC |=>
    $stable(status_r[`NIBBLE_OVF_BIT:`CARRY_BIT]))
    else $error("logic op disturbed carry flags");
  rotKeeps_a: assert property (
    (aluReq.op == status_flags_pkg::FLAG_ROTL
    || aluReq.op == status_flags_pkg::FLAG_ROTR) |=>
    $stable(status_r[`ZERO_BIT:`NIBBLE_OVF_BIT]))
    else $error("rotate disturbed zero or digit flag");
  noOpKeep_a: assert property (
    aluReq.op == status_flags_pkg::FLAG_NONE && !statusWrite |=>
    $stable(status_r[`ZERO_BIT:`CARRY_BIT]))
    else $error("alu flags moved without a cause");

  // a write with no flag op lands in all three alu flags
  plainWrite_a: assert property (
    statusWrite && aluReq.op == status_flags_pkg::FLAG_NONE |=>
    status_r[`ZERO_BIT:`CARRY_BIT] ==
    $past(fileReq.wrData[`ZERO_BIT:`CARRY_BIT]))
    else $error("plain write to alu flags lost");

  // bank selects move only on a write or a warm reset
  bankHold_a: assert property (
    !statusWrite && !warmReset |=>
    $stable(status_r[`INDIRECT_PAGE_BIT:`DIRECT_PAGE_LO]))
    else $error("bank select changed without a write");
  warmClear_a: assert property (
    warmReset |=> status_r[`INDIRECT_PAGE_BIT:`DIRECT_PAGE_LO] == 3'h0)
    else $error("warm reset left a bank selected");

  // reads of other addresses give zero and no hit
  readIdle_a: assert property (
    !(fileReq.rdEn && aliasHit) |=> !readHit_r && readData_r == 8'h00)
    else $error("read outputs active without a read");

  // power-up value of the whole register
  porValue_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    reset |=> status_r == `FLAGS_POR_VALUE)
    else $error("power-up value wrong");

  // main scenarios
  addToStatus_c: cover property (statusWrite
    && aluReq.op == status_flags_pkg::FLAG_ADD);
  sleepThenKick_c: cover property (coreEvent.sleepExec
    ##[1:20] coreEvent.wdtKick);
  timeout_c: cover property (coreEvent.wdtTimeout);
  upperBank_c: cover property (statusWrite && fileReq.wrData[7]);
  warmWrite_c: cover property (warmReset && statusWrite);
endmodule // cpu_status_flag_register

// >>> test/exec_unit_model.sv
// execution unit model: issues file, alu and event requests
// assumes sys_clk from the bench; one instruction per cycle
module exec_unit_model (
  input wire logic sys_clk,
  output status_flags_pkg::file_req_s fileReq,
  output status_flags_pkg::alu_req_s aluReq,
  output status_flags_pkg::core_event_s coreEvent
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    fileReq = '0;
    aluReq = '0;
    coreEvent = '0;
  end
  // one instruction, launched 1 ns after the edge, held a full cycle
  // writes go out with whatever flag op the caller passes in
  task automatic step(input status_flags_pkg::file_req_s f,
    input status_flags_pkg::alu_req_s a,
    input status_flags_pkg::core_event_s e);
    @(posedge sys_clk);
    #1;
    if (!f.wrEn) f.wrData = ~fileReq.wrData;  // released data line toggles
    fileReq = f;
    aluReq = a;
    coreEvent = e;
  endtask
endmodule // exec_unit_model

// >>> test/cpu_status_flag_register_test.sv
// bench for the core flag and bank select register
// assumes the execution unit model issues every request
module cpu_status_flag_register_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0;
  logic reset = 1;
  logic warmReset = 0;
  logic [6:0] directOffset = 7'h00;
  logic [7:0] indirectPtr = 8'h00;
  wire status_flags_pkg::file_req_s fileReq;
  wire status_flags_pkg::alu_req_s aluReq;
  wire status_flags_pkg::core_event_s coreEvent;
  logic [7:0] statusValue, readData_r, s, a, b;
  logic readHit_r, indirect_page_select;
  logic [1:0] direct_page_select;
  logic [8:0] directAddr, indirectAddr;
  logic [7:0] q[$];
  logic [31:0] rng = 32'h0000F162;
  logic [2:0] evs[6] = '{3'h2, 3'h1, 3'h4, 3'h6, 3'h5, 3'h3};
  int n_fail = 0;
  int compares = 0;
  exec_unit_model i_exec_unit_model (.sys_clk, .fileReq, .aluReq,
    .coreEvent);
  cpu_status_flag_register i_cpu_status_flag_register (.sys_clk, .reset,
    .warmReset, .fileReq, .aluReq, .coreEvent, .directOffset,
    .indirectPtr, .statusValue, .readData_r, .readHit_r,
    .indirect_page_select, .direct_page_select, .directAddr,
    .indirectAddr);
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  // xorshift step
  function automatic logic [31:0] nx(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // compare and count
  task automatic chk(input logic [8:0] seen, exp, input string nm);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // counts and verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one instruction: update the expected register, then issue it
  task automatic ins(input status_flags_pkg::flag_op_e op,
    input logic [7:0] a, b, input logic wr, rd, input logic [8:0] ad,
    input logic [7:0] wd, input logic [2:0] ev);
    logic [8:0] t;
    logic [4:0] h;
    logic [7:0] c;
    logic ci;
    ci = (op == status_flags_pkg::FLAG_SUB);
    c = ci ? ~b : b;
    t = a + c + ci;
    h = a[3:0] + c[3:0] + ci;
    rng = nx(rng);
    directOffset = rng[6:0];
    indirectPtr = rng[15:8];
    if (rd && ad[6:0] == 7'h03) q.push_back(s);
    if (wr && ad[6:0] == 7'h03)
      s = {wd[7:5], s[4:3], op ? s[2:0] : wd[2:0]};
    case (op)
      status_flags_pkg::FLAG_LOGIC: s[2] = (a & b) == 8'h00;
      status_flags_pkg::FLAG_ADD, status_flags_pkg::FLAG_SUB:
        s[2:0] = {t[7:0] == 8'h00, h[4], t[8]};
      status_flags_pkg::FLAG_ROTL: s[0] = a[7];
      status_flags_pkg::FLAG_ROTR: s[0] = a[0];
      default: ;
    endcase
    if (ev[2]) s[4:3] = 2'h3;
    else if (ev[1]) s[4:3] = 2'h2;
    if (ev[0]) s[4] = 1'h0;
    i_exec_unit_model.step('{ad, rd, wr, wd}, '{op, a, b, a & b}, ev);
  endtask
  // plain file access or event, no flag op
  task automatic acc(input logic wr, rd, input logic [8:0] ad,
    input logic [7:0] wd, input logic [2:0] ev);
    ins(status_flags_pkg::FLAG_NONE, 8'h00, 8'h00, wr, rd, ad, wd,
      ev);
  endtask
  // read monitor at the falling edge: oldest note against each answer
  always @(negedge sys_clk) begin
    if (readHit_r === 1'h1)
      chk(readData_r, q.size() ? q.pop_front() : 9'h1FF, "readData");
    else if (!reset)
      chk(readData_r, 9'h000, "idleData");
  end
  // hang guard
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  // main sequence
  initial begin
    s = 8'h18;
    repeat (5) @(posedge sys_clk);
    #1 reset = 0;
    acc(0, 1, 9'h003, 8'h00, 3'h0);
    acc(0, 1, 9'h004, 8'h00, 3'h0);
    acc(1, 0, 9'h083, 8'hE7, 3'h0);
    chk(readHit_r, 9'h000, "readHit");
    for (int k = 0; k < 4; k++) acc(0, 1, {k[1:0], 7'h03}, 8'h00, 3'h0);
    for (int k = 0; k < 4; k++) begin
      acc(1, 0, 9'h103, {k[0], k[1:0], 5'h00}, 3'h0);
      acc(0, 0, 9'h000, 8'h00, 3'h0);
      chk(directAddr, {k[1:0], directOffset}, "directAddr");
      chk(indirectAddr, {k[0], indirectPtr}, "indirectAddr");
      chk(statusValue, s, "statusValue");
      chk(direct_page_select, k[1:0], "directPage");
      chk(indirect_page_select, k[0], "indirectPage");
    end
    repeat (48) begin
      rng = nx(rng);
      a = rng[23:16];
      b = rng[24] ? (rng[25] ? a : -a) : rng[31:24];
      ins(status_flags_pkg::flag_op_e'(rng[2:0] % 3'h6), a, b, rng[3], 0,
        {rng[5:4], 7'h03}, rng[15:8], 3'h0);
      acc(0, 1, {rng[7:6], 7'h03}, 8'h00, 3'h0);
    end
    foreach (evs[i]) begin
      acc(0, 0, 9'h000, 8'h00, evs[i]);
      acc(0, 1, 9'h183, 8'h00, 3'h0);
    end
    acc(1, 0, 9'h003, 8'hE0, 3'h0);
    warmReset = 1;
    acc(0, 0, 9'h000, 8'h00, 3'h0);
    warmReset = 0;
    s[7:5] = 3'h0;
    acc(0, 1, 9'h103, 8'h00, 3'h0);
    acc(1, 0, 9'h083, 8'hFF, 3'h0);
    reset = 1;
    acc(0, 0, 9'h000, 8'h00, 3'h0);
    reset = 0;
    s = 8'h18;
    acc(0, 1, 9'h083, 8'h00, 3'h0);
    acc(0, 0, 9'h000, 8'h00, 3'h0);
    acc(0, 0, 9'h000, 8'h00, 3'h0);
    chk(9'(q.size()), 9'h000, "pending");
    close_out();
  end
endmodule // cpu_status_flag_register_test
